/* core/msw_params.svh */
`ifndef MSW_PARAMS_SVH
`define MSW_PARAMS_SVH

// Register byte offsets
`define MSW_OFS_STATUS      12'h000
`define MSW_OFS_CONTROL     12'h004
`define MSW_OFS_BLOCKSIZE   12'h008
`define MSW_OFS_DATA        12'h00c
`define MSW_OFS_FIFOLVL     12'h010
`define MSW_OFS_DELAYFRAC   12'h014
`define MSW_OFS_PHASE       12'h018
`define MSW_OFS_EVENTS      12'h01c

// Status word bit positions
`define MSW_ST_STATE_LO     0
`define MSW_ST_PASSED       2
`define MSW_ST_READY        3
`define MSW_ST_ADC_ERR      4
`define MSW_ST_CLK_FAST     5
`define MSW_ST_SETUP_ERR    6
`define MSW_ST_SYNC_DONE    7
`define MSW_ST_READ_VALID   8
`define MSW_ST_MEAS_DONE    9
`define MSW_ST_ARMED        10
`define MSW_ST_OVERFLOW     11
`define MSW_ST_OVERLOAD     12
`define MSW_ST_ERROR        13
`define MSW_ST_SLOT_N       14
`define MSW_ST_HW_SET       15

// Control register bit positions
`define MSW_CT_FORCE_IDLE   0
`define MSW_CT_SYNC         1
`define MSW_CT_BLOCK_MODE   2
`define MSW_CT_START        3
`define MSW_CT_RESET        4
`define MSW_CT_PH_CAPTURE   5
`define MSW_CT_FREQ_SETUP   6
`define MSW_CT_MSG_NORMAL   7

// Block size limits and reset values
`define MSW_BLK_MIN         24'h000001
`define MSW_BLK_MAX         24'h800000
`define MSW_BLK_RESET       24'h000400
`define MSW_CTRL_RESET      8'h00

// Sync propagation hold, and read point limit
`define MSW_SYNC_HOLD_NS    1000
`define MSW_SYNC_HOLD_CYC   ((`MSW_SYNC_HOLD_NS + 39) / 40)
`define MSW_READ_POINTS_MAX 8

`endif

/* core/msw_pkg.sv */
package msw_pkg;
    typedef enum logic [1:0] {
        MSW_IDLE, MSW_ARM, MSW_MEASURE, MSW_TRIGGER
    } msw_loop_t;

    typedef struct packed {
        logic        sel;
        logic        write;
        logic [11:0] addr;
    } msw_ahb_req_t;

    typedef struct packed {
        logic        adc_fault;
        logic        clk_too_fast;
        logic        overrange;
        logic        pretrig_met;
        logic        trig_event;
        logic        sample_strobe;
        logic        fifo_push;
        logic [15:0] fifo_word;
        logic        err_queue_nonempty;
        logic        cmds_pending;
        logic [15:0] lo_phase;
        logic [15:0] delay_frac;
    } msw_core_ev_t;

    typedef struct packed {
        logic         hreadyout;
        logic [31:0]  hrdata;
        logic         sync_oe_n;
        logic         abort;
        logic         settings_reset;
        msw_ahb_req_t req;
        logic [7:0]   ctrl;
        logic [23:0]  blk_size;
        logic         setup_err;
        logic         adc_err;
        logic         clk_fast;
        logic         overflow;
        logic         overload;
        logic         sync_done;
        logic         meas_done;
        logic [7:0]   sync_hold;
        msw_loop_t    loop;
        logic [23:0]  fifo_lvl;
        logic [23:0]  since_trig;
        logic [15:0] data_word;
        logic [3:0]   reads_left;
        logic         ph_capture;
        logic         ph_valid;
        logic [15:0]  phase;
        logic [15:0]  delay_frac;
        logic [1:0]   sync_sy;
        logic [1:0]   slot_sy;
        logic [1:0]   sync_prev;
    } msw_state_t;
endpackage : msw_pkg

/* core/msw_status_core.sv */
// Contract
// R01 - Status bits 1:0 show loop state: 11 trigger, 10 measure, 01 arm, 00 idle.
// R02 - Status bit 2 always reads one.
// R03 - Bit 3 set when message-based and in normal sub-state.
// R04 - Bit 4 set on converter fault, cleared by status read.
// R05 - Too-fast external clock aborts measurement, sets bit 5, cleared on read.
// R06 - Bit 6 on invalid request; nearest valid block size used meanwhile.
// R07 - Bit 7 set when latest arm or idle change has propagated.
// R08 - Bit 8 set while a 16-bit data word waits in data register.
// R09 - Continuous mode: bit 9 when buffer level reaches block size.
// R10 - Block mode: bit 9 after block-size samples since last trigger.
// R11 - Bit 10 in trigger or armed-ready state; arm line released then.
// R12 - Arm to trigger only when every module released shared arm line.
// R13 - Bit 11 set on buffer overflow in continuous mode.
// R14 - Bit 12 set on converter overrange, cleared by status read.
// R15 - Bit 13 follows error queue non-empty.
// R16 - Bit 14 low when slot select line is high, high otherwise.
// R17 - Bit 15 set only when commands done and hardware settled.
// R18 - Reset command restores power-up settings, keeps calibration constants.
// R19 - Scaled reads only via data register, at most eight points per request.
// R20 - Phase reported as unsigned fraction of a cycle, quarter is 90 degrees.
// R21 - Fractional trigger-to-sample offset captured at each trigger.
// R22 - Frequency or filter setup leaves phase capture mode.
// R23 - Shared arm line is wired: asserted if any module asserts it.
// R24 - Read-clear bits cleared only after captured into returned word.
//
// Implementation choices: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "msw_params.svh"

module msw_status_core (
    input  wire logic                 core_clk,
    input  wire logic                 reset_n,
    input  wire logic                 hsel,
    input  wire logic [11:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    input  wire logic                 sync_line_in,
    output logic                      sync_line_oe_n,
    input  wire logic                 slot_select_pin,
    input  wire msw_pkg::msw_core_ev_t core_ev,
    output logic                      meas_abort,
    output logic                      settings_reset
);
    import msw_pkg::*;

    localparam int HOLD_W = 8;

    msw_state_t s;
    msw_state_t next_s;
    logic [15:0] status_word;
    logic        status_read;
    logic        rd_take;
    logic        data_read;
    logic        wr_ok;
    logic        sync_rel;
    logic        armed;
    logic        blk_mode;

    ////////////////////////////////////////////////////////////////////////////
    // Status word assembly
    always_comb begin
        armed    = (s.loop == MSW_TRIGGER) || ((s.loop == MSW_ARM) && core_ev.pretrig_met);
        blk_mode = s.ctrl[`MSW_CT_BLOCK_MODE];
        status_word = 16'h0000;
        // R01 loop state code
        status_word[`MSW_ST_STATE_LO +: 2] = s.loop;
        // R02 always passed
        status_word[`MSW_ST_PASSED]     = 1'b1;
        // R03 normal sub-state
        status_word[`MSW_ST_READY]      = s.ctrl[`MSW_CT_MSG_NORMAL];
        status_word[`MSW_ST_ADC_ERR]    = s.adc_err;
        status_word[`MSW_ST_CLK_FAST]   = s.clk_fast;
        status_word[`MSW_ST_SETUP_ERR]  = s.setup_err;
        status_word[`MSW_ST_SYNC_DONE]  = s.sync_done;
        // R08 data word waiting
        status_word[`MSW_ST_READ_VALID] = (s.fifo_lvl != 24'h000000);
        status_word[`MSW_ST_MEAS_DONE]  = s.meas_done;
        // R11 armed indication
        status_word[`MSW_ST_ARMED]      = armed;
        status_word[`MSW_ST_OVERFLOW]   = s.overflow;
        status_word[`MSW_ST_OVERLOAD]   = s.overload;
        // R15 error queue flag
        status_word[`MSW_ST_ERROR]      = core_ev.err_queue_nonempty;
        // R16 inverted slot select
        status_word[`MSW_ST_SLOT_N]     = ~s.slot_sy[1];
        // R17 hardware set
        status_word[`MSW_ST_HW_SET]     = ~core_ev.cmds_pending && ~s.settings_reset;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        next_s = s;
        next_s.sync_sy   = {s.sync_sy[0], sync_line_in};
        next_s.slot_sy   = {s.slot_sy[0], slot_select_pin};
        next_s.sync_prev = {s.sync_prev[0], s.sync_sy[1]};
        sync_rel = ~s.sync_sy[1];
        next_s.abort = 1'b0;
        next_s.settings_reset = 1'b0;

        // AHB address phase capture; the slave is always ready
        next_s.hreadyout = 1'b1;
        if (hready) begin
            next_s.req.sel   = hsel && htrans[1];
            next_s.req.write = hwrite;
            next_s.req.addr  = haddr;
        end
        rd_take     = hready && hsel && htrans[1] && !hwrite;
        status_read = rd_take && (haddr == `MSW_OFS_STATUS);
        data_read   = s.req.sel && !s.req.write && (s.req.addr == `MSW_OFS_DATA);
        wr_ok       = s.req.sel && s.req.write;

        // Read data is loaded at the address phase edge so it stands in the data phase.
        // A read overlapping the data phase of a write to the same register sees the old value.
        // R24 word captured at the same edge as the clear
        if (rd_take) begin
            case (haddr)
                `MSW_OFS_STATUS:    next_s.hrdata = {16'h0000, status_word};
                `MSW_OFS_CONTROL:   next_s.hrdata = {24'h000000, s.ctrl};
                `MSW_OFS_BLOCKSIZE: next_s.hrdata = {8'h00, s.blk_size};
                // R19 scaled reads only here
                `MSW_OFS_DATA:      next_s.hrdata = {16'h0000, s.data_word};
                `MSW_OFS_FIFOLVL:   next_s.hrdata = {8'h00, s.fifo_lvl};
                `MSW_OFS_DELAYFRAC: next_s.hrdata = {16'h0000, s.delay_frac};
                `MSW_OFS_PHASE:     next_s.hrdata = {15'h0000, s.ph_valid, s.phase};
                `MSW_OFS_EVENTS:    next_s.hrdata = {28'h0000000, s.reads_left};
                default:            next_s.hrdata = 32'h00000000;
            endcase
        end

        // R04 converter fault sticky
        if (status_read) next_s.adc_err = 1'b0;
        if (core_ev.adc_fault) next_s.adc_err = 1'b1;
        // R14 overrange sticky
        if (status_read) next_s.overload = 1'b0;
        if (core_ev.overrange) next_s.overload = 1'b1;
        // R05 clock too fast
        if (status_read) next_s.clk_fast = 1'b0;
        if (core_ev.clk_too_fast && s.loop != MSW_IDLE) begin
            next_s.clk_fast = 1'b1;
            next_s.abort    = 1'b1;
            next_s.loop     = MSW_IDLE;
        end

        // Register writes
        if (wr_ok) begin
            case (s.req.addr)
                `MSW_OFS_CONTROL: begin
                    next_s.ctrl = hwdata[7:0] & ~8'h58;
                    // R07 new arm or idle request
                    if (hwdata[`MSW_CT_SYNC] || hwdata[`MSW_CT_FORCE_IDLE]) begin
                        next_s.sync_done = 1'b0;
                        next_s.sync_hold = HOLD_W'(`MSW_SYNC_HOLD_CYC);
                    end
                    // R22 setup leaves capture mode
                    if (hwdata[`MSW_CT_FREQ_SETUP]) next_s.ph_capture = 1'b0;
                    else if (hwdata[`MSW_CT_PH_CAPTURE]) begin
                        next_s.ph_capture = 1'b1;
                        next_s.ph_valid   = 1'b0;
                    end
                    if (hwdata[`MSW_CT_START] && s.loop == MSW_IDLE) begin
                        next_s.loop = MSW_ARM;
                    end
                end
                `MSW_OFS_BLOCKSIZE: begin
                    // R06 clamp to nearest valid
                    next_s.setup_err = 1'b0;
                    if (hwdata[23:0] < `MSW_BLK_MIN) begin
                        next_s.blk_size  = `MSW_BLK_MIN;
                        next_s.setup_err = 1'b1;
                    end else if (hwdata[23:0] > `MSW_BLK_MAX || hwdata[31:24] != 8'h00) begin
                        next_s.blk_size  = `MSW_BLK_MAX;
                        next_s.setup_err = 1'b1;
                    end else begin
                        next_s.blk_size  = hwdata[23:0];
                    end
                end
                `MSW_OFS_EVENTS: begin
                    // R19 point count per request
                    if (hwdata[3:0] == 4'h0 || hwdata[3:0] > 4'(`MSW_READ_POINTS_MAX))
                        next_s.setup_err = 1'b1;
                    else
                        next_s.reads_left = hwdata[3:0];
                end
                default: ;
            endcase
        end

        // Sync propagation timer
        if (s.sync_hold != '0) begin
            next_s.sync_hold = s.sync_hold - HOLD_W'(1);
        end else if (!s.sync_done && !(wr_ok && s.req.addr == `MSW_OFS_CONTROL)) begin
            next_s.sync_done = 1'b1;
            next_s.ctrl[`MSW_CT_SYNC] = 1'b0;
        end

        // FIFO occupancy model and data register
        if (data_read && s.reads_left != 4'h0) next_s.reads_left = s.reads_left - 4'h1;
        if (core_ev.fifo_push && !(data_read && s.fifo_lvl != '0)) begin
            if (s.fifo_lvl == 24'hffffff) begin
                // R13 overflow in continuous mode
                if (!blk_mode) begin
                    next_s.overflow = 1'b1;
                    next_s.loop     = MSW_IDLE;
                end
            end else begin
                next_s.fifo_lvl = s.fifo_lvl + 24'h000001;
            end
        end else if (!core_ev.fifo_push && data_read && s.fifo_lvl != '0) begin
            next_s.fifo_lvl = s.fifo_lvl - 24'h000001;
        end
        if (core_ev.fifo_push) next_s.data_word = core_ev.fifo_word;

        // R09 continuous-mode done
        if (!blk_mode) next_s.meas_done = (next_s.fifo_lvl >= s.blk_size);

        // Measurement loop
        case (s.loop)
            MSW_IDLE: begin
                if (s.sync_prev == 2'b10 && !s.ctrl[`MSW_CT_FORCE_IDLE])
                    next_s.loop = MSW_ARM;
            end
            MSW_ARM: begin
                // R12 all modules released
                if (armed && sync_rel) next_s.loop = MSW_TRIGGER;
            end
            MSW_TRIGGER: begin
                if (core_ev.trig_event) begin
                    next_s.loop       = MSW_MEASURE;
                    next_s.since_trig = '0;
                    // R21 fractional delay capture
                    next_s.delay_frac = core_ev.delay_frac;
                    // R20 phase fraction capture
                    if (s.ph_capture) begin
                        next_s.phase    = core_ev.lo_phase;
                        next_s.ph_valid = 1'b1;
                    end
                    if (blk_mode) next_s.meas_done = 1'b0;
                end
            end
            MSW_MEASURE: begin
                if (core_ev.sample_strobe && s.since_trig != s.blk_size)
                    next_s.since_trig = s.since_trig + 24'h000001;
                // R10 block collected
                if (blk_mode && s.since_trig == s.blk_size) next_s.meas_done = 1'b1;
                // The release that ends a block must not re-arm from idle
                if (blk_mode && s.meas_done && sync_rel) begin
                    next_s.loop      = MSW_IDLE;
                    next_s.sync_prev = 2'b00;
                end
            end
            default: next_s.loop = MSW_IDLE;
        endcase
        if (s.ctrl[`MSW_CT_FORCE_IDLE] && next_s.loop != MSW_IDLE) next_s.loop = MSW_IDLE;

        // R11 release when armed; R23 wired arm line
        next_s.sync_oe_n = ~((s.ctrl[`MSW_CT_SYNC] && !armed)
                           || (s.loop == MSW_MEASURE && blk_mode && !s.meas_done)
                           || (s.loop == MSW_ARM && !armed));

        // R18 reset command; calibration held elsewhere stays
        if (wr_ok && s.req.addr == `MSW_OFS_CONTROL && hwdata[`MSW_CT_RESET]) begin
            next_s.ctrl       = `MSW_CTRL_RESET;
            next_s.blk_size   = `MSW_BLK_RESET;
            next_s.loop       = MSW_IDLE;
            next_s.setup_err  = 1'b0;
            next_s.overflow   = 1'b0;
            next_s.meas_done  = 1'b0;
            next_s.fifo_lvl   = '0;
            next_s.since_trig = '0;
            next_s.reads_left = '0;
            next_s.ph_capture = 1'b0;
            next_s.ph_valid   = 1'b0;
            next_s.sync_oe_n  = 1'b1;
            next_s.settings_reset = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s            <= '0;
            s.hreadyout  <= 1'b1;
            s.sync_oe_n  <= 1'b1;
            s.sync_done  <= 1'b1;
            s.ctrl       <= `MSW_CTRL_RESET;
            s.blk_size   <= `MSW_BLK_RESET;
            s.loop       <= MSW_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign hreadyout      = s.hreadyout;
    assign hresp          = 1'b0;
    assign hrdata         = s.hrdata;
    assign sync_line_oe_n = s.sync_oe_n;
    assign meas_abort     = s.abort;
    assign settings_reset = s.settings_reset;

endmodule : msw_status_core

/* sim/msw_sibling.sv */
`timescale 1ns/10ps
module msw_sibling (
    input  wire logic core_clk,
    input  wire logic hold_arm,
    input  wire logic dut_oe_n,
    output logic      arm_line
);
    logic sib_drive = 1'b0;
    always_ff @(posedge core_clk) begin
        sib_drive <= hold_arm;
    end
    assign arm_line = sib_drive | ~dut_oe_n;
endmodule : msw_sibling

/* sim/msw_status_chk.sv */
`timescale 1ns/10ps
`include "msw_params.svh"
module msw_status_chk (
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic        hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        sync_line_oe_n,
    input wire logic        meas_abort,
    input wire logic        settings_reset
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    logic rd_take;
    logic rd_st;
    assign rd_take = hsel && htrans[1] && hready && !hwrite;
    assign rd_st   = rd_take && haddr == `MSW_OFS_STATUS;
    ready_high_a: assert property (hreadyout)
        else $error("hreadyout low");
    resp_okay_a: assert property (!hresp)
        else $error("hresp not okay");
    passed_bit_a: assert property (rd_st |-> ##1 hrdata[2])
        else $error("passed bit clear");
    unmapped_zero_a: assert property (rd_take && haddr > `MSW_OFS_EVENTS |-> ##1 hrdata == 32'h0)
        else $error("unmapped read not zero");
    abort_pulse_a: assert property ($rose(meas_abort) |=> !meas_abort)
        else $error("abort pulse too long");
    reset_pulse_a: assert property ($rose(settings_reset) |=> !settings_reset)
        else $error("reset pulse too long");
    armed_release_a: assert property (rd_st ##1 hrdata[10] |-> sync_line_oe_n)
        else $error("arm line held while armed");
    trig_release_a: assert property (rd_st ##1 hrdata[1:0] == 2'b11 |-> sync_line_oe_n)
        else $error("arm line held in trigger");
endmodule : msw_status_chk

bind msw_status_core msw_status_chk chk (.core_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite,
    .hready, .hreadyout, .hresp, .hrdata, .sync_line_oe_n, .meas_abort, .settings_reset);

/* sim/tb_top.sv */
`timescale 1ns/10ps
`include "msw_params.svh"
module tb_top;
    import msw_pkg::*;
    logic         core_clk = 1'b0;
    logic         reset_n  = 1'b0;
    logic         hsel     = 1'b0;
    logic [11:0]  haddr    = 12'h000;
    logic [1:0]   htrans   = 2'b00;
    logic         hwrite   = 1'b0;
    logic [31:0]  hwdata   = 32'h0;
    logic         hold_arm = 1'b0;
    logic         slot_sel = 1'b1;
    msw_core_ev_t ev       = '0;
    logic         hready;
    logic         hresp;
    logic [31:0]  hrdata;
    logic         oe_n;
    logic         arm_line;
    logic         meas_abort;
    logic         settings_reset;
    int           miscompares = 0;
    int           checks_done = 0;
    int           aborts = 0;
    int           resets = 0;

    msw_status_core DUT (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .sync_line_in(arm_line),
        .sync_line_oe_n(oe_n), .slot_select_pin(slot_sel), .core_ev(ev),
        .meas_abort(meas_abort), .settings_reset(settings_reset));
    msw_sibling sib (.core_clk(core_clk), .hold_arm(hold_arm), .dut_oe_n(oe_n),
        .arm_line(arm_line));

    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (meas_abort === 1'b1) aborts++;
        if (settings_reset === 1'b1) resets++;
    end
    ////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
    endtask : tick

    // Bounded wait for hready at a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge core_clk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 50) begin
                miscompares++;
                report_and_stop();
            end
            @(posedge core_clk);
        end
    endtask : wait_rdy

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask : bus

    task automatic st(input logic [15:0] mask, input logic [15:0] exp);
        logic [31:0] q;
        bus(1'b0, `MSW_OFS_STATUS, 32'h0, q);
        check({16'h0, q[15:0] & mask}, {16'h0, exp});
    endtask : st
    ////////////////////////////////////////
    task automatic t_idle;
        logic [31:0] q;
        st(16'hff7f, 16'h8004);
        bus(1'b0, 12'h040, 32'h0, q);
        check(q, 32'h0);
    endtask : t_idle

    task automatic t_flags;
        logic [31:0] q;
        ev.adc_fault <= 1'b1;
        ev.overrange <= 1'b1;
        ev.err_queue_nonempty <= 1'b1;
        ev.cmds_pending <= 1'b1;
        slot_sel <= 1'b0;
        tick(1);
        ev.adc_fault <= 1'b0;
        ev.overrange <= 1'b0;
        bus(1'b1, `MSW_OFS_CONTROL, 32'h80, q);
        tick(4);
        st(16'hf018, 16'h7018);
        st(16'hf018, 16'h6008);
        ev.err_queue_nonempty <= 1'b0;
        ev.cmds_pending <= 1'b0;
        slot_sel <= 1'b1;
        tick(4);
        st(16'hf018, 16'h8008);
    endtask : t_flags

    task automatic t_block;
        logic [31:0] q;
        bus(1'b1, `MSW_OFS_BLOCKSIZE, 32'h1, q);
        ev.fifo_word <= 16'hbeef;
        ev.fifo_push <= 1'b1;
        tick(1);
        ev.fifo_push <= 1'b0;
        tick(2);
        st(16'h0300, 16'h0300);
        bus(1'b0, `MSW_OFS_DATA, 32'h0, q);
        check(q & 32'hffff, 32'hbeef);
        st(16'h0100, 16'h0000);
        bus(1'b1, `MSW_OFS_BLOCKSIZE, 32'h0, q);
        bus(1'b0, `MSW_OFS_BLOCKSIZE, 32'h0, q);
        check(q, 32'h1);
        st(16'h0040, 16'h0040);
        bus(1'b1, `MSW_OFS_CONTROL, 32'h10, q);
        tick(2);
        check(resets, 1);
        bus(1'b0, `MSW_OFS_BLOCKSIZE, 32'h0, q);
        check(q, 32'h400);
    endtask : t_block

    task automatic t_arm;
        logic [31:0] q;
        hold_arm <= 1'b1;
        bus(1'b1, `MSW_OFS_CONTROL, 32'h8, q);
        tick(4);
        st(16'h0403, 16'h0001);
        check({31'h0, oe_n}, 32'h0);
        ev.pretrig_met <= 1'b1;
        tick(4);
        st(16'h0403, 16'h0401);
        check({31'h0, oe_n}, 32'h1);
        hold_arm <= 1'b0;
        tick(6);
        st(16'h0403, 16'h0403);
        ev.trig_event <= 1'b1;
        tick(1);
        ev.trig_event <= 1'b0;
        tick(4);
        st(16'h0003, 16'h0002);
        ev.clk_too_fast <= 1'b1;
        tick(1);
        ev.clk_too_fast <= 1'b0;
        tick(4);
        st(16'h0023, 16'h0020);
        check(aborts, 1);
        st(16'h0020, 16'h0000);
    endtask : t_arm

    task automatic t_sync;
        logic [31:0] q;
        bus(1'b1, `MSW_OFS_BLOCKSIZE, 32'h2, q);
        bus(1'b1, `MSW_OFS_CONTROL, 32'h26, q);
        st(16'h0080, 16'h0000);
        check({31'h0, oe_n}, 32'h0);
        tick(40);
        st(16'h0083, 16'h0083);
        ev.lo_phase   <= 16'h4000;
        ev.delay_frac <= 16'h1234;
        ev.trig_event <= 1'b1;
        tick(1);
        ev.trig_event <= 1'b0;
        tick(4);
        st(16'h0203, 16'h0002);
        ev.sample_strobe <= 1'b1;
        tick(2);
        ev.sample_strobe <= 1'b0;
        tick(8);
        st(16'h0203, 16'h0200);
        bus(1'b0, `MSW_OFS_PHASE, 32'h0, q);
        check(q, 32'h00014000);
        bus(1'b0, `MSW_OFS_DELAYFRAC, 32'h0, q);
        check(q, 32'h00001234);
        bus(1'b1, `MSW_OFS_EVENTS, 32'h9, q);
        st(16'h0040, 16'h0040);
        bus(1'b1, `MSW_OFS_EVENTS, 32'h8, q);
        bus(1'b0, `MSW_OFS_EVENTS, 32'h0, q);
        check(q, 32'h8);
    endtask : t_sync

    initial begin
        tick(3);
        reset_n <= 1'b1;
        tick(3);
        t_idle();
        t_flags();
        t_block();
        t_arm();
        t_sync();
        report_and_stop();
    end
endmodule : tb_top
